// *** common/bus_ctl_pkg.sv ***
/*
  Shared constants and types for the local bus control and hold block.
  Assumes one system clock; each bus T-state is two system clocks.
*/
package bus_ctl_pkg;

  ////////////////////////////////////////////////////////////////////
  // Timing
  // System clock rate in hertz
  localparam int unsigned CLK_SYS_HZ = 25000000;
  // Target T-state rate in hertz, a divide by two
  localparam int unsigned TSTATE_HZ = 12500000;
  // System clocks per T-state, derived from the two rates
  localparam int unsigned CLKS_PER_TSTATE = CLK_SYS_HZ / TSTATE_HZ;
  // Phase of a T-state: first half, second half
  localparam logic PHASE_FIRST = 1'h0;
  localparam logic PHASE_SECOND = 1'h1;

  ////////////////////////////////////////////////////////////////////
  // States and sources
  // Bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_T3, ST_TW, ST_T4, ST_HOLD, ST_DEAD
  } bus_state_t;
  // Who asked for the bus
  typedef enum logic [1:0] {
    SRC_HOLD_PIN, SRC_RG_HI, SRC_RG_LO
  } req_src_t;

  ////////////////////////////////////////////////////////////////////
  // Carriers
  // Attributes of a bus cycle from the core
  typedef struct packed {
    logic is_mem;
    logic is_write;
    logic is_int_ack_strobe_n;
    logic int_ack_strobe_n_first;
    logic split_low;
  } cyc_attr_t;
  // Bus strobes as driven on the pins
  typedef struct packed {
    logic ale;
    logic wr_n;
    logic int_ack_strobe_n;
    logic m_io;
    logic transceiver_direction;
    logic transceiver_enable_n;
  } strobe_t;

  ////////////////////////////////////////////////////////////////////
  // Reset values
  localparam cyc_attr_t ATTR_RESET = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0};
  localparam strobe_t STROBE_RESET = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1};
  localparam logic [1:0] QS_RESET = 2'h0;

endpackage : bus_ctl_pkg

// *** design/cpu_local_bus_control_and_hold.sv ***
/*
  Bus control strobes, lock, queue status and bus hold handover of a
  multiplexed local bus processor.
  Assumes the core holds cyc_req_in with attributes until cyc_ack_out,
  all inputs synchronous to clk_sys_in, and open drain wires resolved
  outside from the output enables.
*/
`timescale 1ns/100ps

module cpu_local_bus_control_and_hold (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Core cycle request
  input wire logic cyc_req_in,
  input wire bus_ctl_pkg::cyc_attr_t cyc_attr_in,
  input wire logic ready_in,
  input wire logic lock_active_in,
  input wire logic [1:0] queue_op_in,
  output logic cyc_ack_out,
  output logic cyc_done_out,
  // Bus strobes
  output logic ale_out,
  output logic wr_n_out,
  output logic int_ack_strobe_n_out,
  output logic m_io_out,
  output logic transceiver_direction_out,
  output logic transceiver_enable_n_out,
  output logic lock_n_out,
  output logic bus_oe_out,
  output logic [1:0] queue_status_out,
  // Hold handshake
  input wire logic hold_req_in,
  output logic bus_hold_ack_out,
  // Request/grant open drain lines
  input wire logic request_grant_line_hi_pri_in,
  output logic request_grant_line_hi_pri_out,
  output logic request_grant_line_hi_pri_oe_out,
  input wire logic request_grant_line_lo_pri_in,
  output logic request_grant_line_lo_pri_out,
  output logic request_grant_line_lo_pri_oe_out
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  logic phase_reg; // Half of current T-state
  logic tick; // Last clock of a T-state
  logic mid; // Clock ending the first half
  bus_ctl_pkg::bus_state_t state_reg; // Sequencer state
  bus_ctl_pkg::bus_state_t state_next;
  logic rel_reg; // Current T4/idle is a release state
  logic rel_next;
  logic go_reg; // Next cycle latched
  logic latch_go; // Latch a cycle this clock
  bus_ctl_pkg::cyc_attr_t attr_reg; // Attributes of current cycle
  bus_ctl_pkg::cyc_attr_t attr_next;
  logic locked_reg; // Cycle belongs to a locked instruction
  logic pend_reg; // Bus request waiting
  bus_ctl_pkg::req_src_t src_reg; // Source of the request
  logic early_reg; // Request seen on or before T2
  logic capture; // New request taken this tick
  bus_ctl_pkg::req_src_t src_now; // Source as seen this clock
  logic ok_cycle; // Release allowed at this T4
  logic drive_reg; // Bus and control lines driven
  logic hold_ack_reg; // Hold acknowledge
  logic [1:0] rg_oe_reg; // Grant pulse enables
  logic rg_zero_reg; // Level driven on request/grant lines
  bus_ctl_pkg::strobe_t strobe_reg; // Registered strobes
  logic lock_n_reg; // Registered lock
  logic [1:0] qs_reg; // Registered queue status
  logic ack_reg; // Cycle accepted pulse
  logic done_reg; // Cycle finished pulse

  ////////////////////////////////////////////////////////////////////
  // Strobe decode from state, half and cycle attributes
  function automatic bus_ctl_pkg::strobe_t strobe_decode(
    input bus_ctl_pkg::bus_state_t st,
    input logic ph,
    input bus_ctl_pkg::cyc_attr_t at
  );
    bus_ctl_pkg::strobe_t s;
    logic data_phase;
    logic read_en;
    logic write_en;
    data_phase = (st == bus_ctl_pkg::ST_T2) || (st == bus_ctl_pkg::ST_T3)
      || (st == bus_ctl_pkg::ST_TW);
    read_en = ((st == bus_ctl_pkg::ST_T2) && (ph == bus_ctl_pkg::PHASE_SECOND))
      || ((st == bus_ctl_pkg::ST_T3) && (ph == bus_ctl_pkg::PHASE_FIRST));
    write_en = data_phase
      || ((st == bus_ctl_pkg::ST_T4) && (ph == bus_ctl_pkg::PHASE_FIRST));
    s.ale = (st == bus_ctl_pkg::ST_T1);
    s.wr_n = !(at.is_write && data_phase);
    s.int_ack_strobe_n = !(at.is_int_ack_strobe_n && data_phase);
    s.m_io = at.is_mem;
    s.transceiver_direction = at.is_write;
    s.transceiver_enable_n = at.is_write ? !write_en : !read_en;
    return s;
  endfunction : strobe_decode

  ////////////////////////////////////////////////////////////////////
  // T-state divider
  assign tick = (phase_reg == bus_ctl_pkg::PHASE_SECOND);
  assign mid = (phase_reg == bus_ctl_pkg::PHASE_FIRST);

  // Toggle half each clock
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      phase_reg <= bus_ctl_pkg::PHASE_FIRST;
    else
      phase_reg <= ~phase_reg;
  end

  ////////////////////////////////////////////////////////////////////
  // Request capture and release conditions
  // request pulse or hold level, high priority first
  assign capture = tick && !pend_reg && !rel_reg
    && (state_reg != bus_ctl_pkg::ST_HOLD)
    && (state_reg != bus_ctl_pkg::ST_DEAD)
    && (!request_grant_line_hi_pri_in || !request_grant_line_lo_pri_in
    || hold_req_in);
  // five release conditions, shared by hold
  assign ok_cycle = pend_reg && early_reg && !attr_reg.split_low
    && !attr_reg.int_ack_strobe_n_first && !locked_reg;
  // Source of a request taken this clock, so the grant sees it at once
  assign src_now = !capture ? src_reg
    : !request_grant_line_hi_pri_in ? bus_ctl_pkg::SRC_RG_HI
    : !request_grant_line_lo_pri_in ? bus_ctl_pkg::SRC_RG_LO
    : bus_ctl_pkg::SRC_HOLD_PIN;

  // Pending request and its source
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      pend_reg <= 1'h0;
      src_reg <= bus_ctl_pkg::SRC_HOLD_PIN;
    end
    else if (capture)
    begin
      pend_reg <= 1'h1;
      // hold sampled on the clock like the lines
      if (!request_grant_line_hi_pri_in)
        src_reg <= bus_ctl_pkg::SRC_RG_HI;
      else if (!request_grant_line_lo_pri_in)
        src_reg <= bus_ctl_pkg::SRC_RG_LO;
      else
        src_reg <= bus_ctl_pkg::SRC_HOLD_PIN;
    end
    else if (tick && (state_next == bus_ctl_pkg::ST_HOLD))
      pend_reg <= 1'h0;
  end

  // Request timing: seen by T2 of the cycle that may release
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      early_reg <= 1'h0;
    else if (tick && (state_next == bus_ctl_pkg::ST_HOLD))
      early_reg <= 1'h0;
    // idle request counts as early for the next cycle
    else if (tick && (pend_reg || capture)
      && ((state_reg == bus_ctl_pkg::ST_IDLE)
      || (state_reg == bus_ctl_pkg::ST_T1)
      || (state_reg == bus_ctl_pkg::ST_T2)
      || (state_reg == bus_ctl_pkg::ST_T4)))
      early_reg <= 1'h1;
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb
  begin
    state_next = state_reg;
    rel_next = rel_reg;
    if (tick)
    begin
      unique case (state_reg)
        // Idle: release, start a cycle or stay
        bus_ctl_pkg::ST_IDLE:
        begin
          if (rel_reg)
          begin
            state_next = bus_ctl_pkg::ST_HOLD;
            rel_next = 1'h0;
          end
          else if (go_reg)
            state_next = bus_ctl_pkg::ST_T1;
          else
            rel_next = pend_reg || capture;
        end
        bus_ctl_pkg::ST_T1:
          state_next = bus_ctl_pkg::ST_T2;
        bus_ctl_pkg::ST_T2:
          state_next = bus_ctl_pkg::ST_T3;
        bus_ctl_pkg::ST_T3, bus_ctl_pkg::ST_TW:
        begin
          if (ready_in)
          begin
            state_next = bus_ctl_pkg::ST_T4;
            rel_next = ok_cycle;
          end
          else
            state_next = bus_ctl_pkg::ST_TW;
        end
        // End of cycle: release, next cycle or idle
        bus_ctl_pkg::ST_T4:
        begin
          if (rel_reg)
          begin
            state_next = bus_ctl_pkg::ST_HOLD;
            rel_next = 1'h0;
          end
          else if (go_reg)
            state_next = bus_ctl_pkg::ST_T1;
          else
          begin
            state_next = bus_ctl_pkg::ST_IDLE;
            rel_next = pend_reg || capture;
          end
        end
        // Leave hold on release pulse or hold low
        bus_ctl_pkg::ST_HOLD:
        begin
          if ((src_reg == bus_ctl_pkg::SRC_HOLD_PIN) && !hold_req_in)
            state_next = bus_ctl_pkg::ST_IDLE;
          else if ((src_reg == bus_ctl_pkg::SRC_RG_HI)
            && !request_grant_line_hi_pri_in)
            state_next = bus_ctl_pkg::ST_DEAD;
          else if ((src_reg == bus_ctl_pkg::SRC_RG_LO)
            && !request_grant_line_lo_pri_in)
            state_next = bus_ctl_pkg::ST_DEAD;
        end
        // one dead T-state after the exchange
        bus_ctl_pkg::ST_DEAD:
          state_next = bus_ctl_pkg::ST_IDLE;
      endcase
    end
  end

  // State and release flag
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      state_reg <= bus_ctl_pkg::ST_IDLE;
      rel_reg <= 1'h0;
    end
    else
    begin
      state_reg <= state_next;
      rel_reg <= rel_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Cycle latch at mid T4 or idle
  assign latch_go = mid && cyc_req_in && !go_reg && !rel_reg
    && ((state_reg == bus_ctl_pkg::ST_T4) || (state_reg == bus_ctl_pkg::ST_IDLE));
  assign attr_next = latch_go ? cyc_attr_in : attr_reg;

  // Latch attributes and lock of the next cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      go_reg <= 1'h0;
      attr_reg <= bus_ctl_pkg::ATTR_RESET;
      locked_reg <= 1'h0;
    end
    else if (latch_go)
    begin
      go_reg <= 1'h1;
      attr_reg <= cyc_attr_in;
      locked_reg <= lock_active_in;
    end
    else if (tick && (state_next == bus_ctl_pkg::ST_T1))
      go_reg <= 1'h0;
  end

  // Core handshake pulses
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      ack_reg <= 1'h0;
      done_reg <= 1'h0;
    end
    else
    begin
      ack_reg <= tick && (state_next == bus_ctl_pkg::ST_T1);
      done_reg <= tick && (state_reg == bus_ctl_pkg::ST_T4);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus ownership outputs
  // Drive enable of floating lines
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      drive_reg <= 1'h1;
    // drive again only for the next cycle
    else if (latch_go)
      drive_reg <= 1'h1;
    else if (tick && rel_next && !rel_reg && (src_now != bus_ctl_pkg::SRC_HOLD_PIN))
      drive_reg <= 1'h0;
    else if (mid && rel_reg && (src_reg == bus_ctl_pkg::SRC_HOLD_PIN))
      drive_reg <= 1'h0;
  end

  // Hold acknowledge
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      hold_ack_reg <= 1'h0;
    else if (mid && rel_reg && (src_reg == bus_ctl_pkg::SRC_HOLD_PIN))
      hold_ack_reg <= 1'h1;
    else if (tick && (state_reg == bus_ctl_pkg::ST_HOLD) && !hold_req_in)
      hold_ack_reg <= 1'h0;
  end

  // Grant pulse, one T-state wide
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      rg_oe_reg <= 2'h0;
      rg_zero_reg <= 1'h0;
    end
    else if (tick)
    begin
      // grant during the release T4 or idle
      rg_oe_reg[0] <= rel_next && !rel_reg && (src_now == bus_ctl_pkg::SRC_RG_HI);
      rg_oe_reg[1] <= rel_next && !rel_reg && (src_now == bus_ctl_pkg::SRC_RG_LO);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Strobes, lock and queue status
  // Strobes from next state and half
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      strobe_reg <= bus_ctl_pkg::STROBE_RESET;
    else
      strobe_reg <= strobe_decode(state_next, ~phase_reg, attr_next);
  end

  // lock follows the core lock span
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      lock_n_reg <= 1'h1;
    else
      lock_n_reg <= !lock_active_in;
  end

  // queue op shown in the next T-state
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      qs_reg <= bus_ctl_pkg::QS_RESET;
    else if (tick)
      qs_reg <= queue_op_in;
  end

  ////////////////////////////////////////////////////////////////////
  // Output wiring, all from flops
  assign cyc_ack_out = ack_reg;
  assign cyc_done_out = done_reg;
  assign ale_out = strobe_reg.ale;
  assign wr_n_out = strobe_reg.wr_n;
  assign int_ack_strobe_n_out = strobe_reg.int_ack_strobe_n;
  assign m_io_out = strobe_reg.m_io;
  assign transceiver_direction_out = strobe_reg.transceiver_direction;
  assign transceiver_enable_n_out = strobe_reg.transceiver_enable_n;
  assign lock_n_out = lock_n_reg;
  // one enable floats lock and control lines
  assign bus_oe_out = drive_reg;
  assign queue_status_out = qs_reg;
  assign bus_hold_ack_out = hold_ack_reg;
  assign request_grant_line_hi_pri_out = rg_zero_reg;
  assign request_grant_line_hi_pri_oe_out = rg_oe_reg[0];
  assign request_grant_line_lo_pri_out = rg_zero_reg;
  assign request_grant_line_lo_pri_oe_out = rg_oe_reg[1];

endmodule : cpu_local_bus_control_and_hold

// *** verification/bus_ctl_sva.sv ***
/* Checker for the bus control and hold block.
   Sees only the top ports; bound from the testbench. */
`timescale 1ns/100ps
module bus_ctl_sva (
  // Clock, reset, core side
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire bus_ctl_pkg::cyc_attr_t cyc_attr_in,
  input wire logic lock_active_in,
  input wire logic cyc_ack_out,
  // Watched outputs
  input wire logic ale_out,
  input wire logic wr_n_out,
  input wire logic int_ack_strobe_n_out,
  input wire logic m_io_out,
  input wire logic transceiver_direction_out,
  input wire logic transceiver_enable_n_out,
  input wire logic lock_n_out,
  input wire logic bus_oe_out,
  input wire logic bus_hold_ack_out,
  input wire logic request_grant_line_hi_pri_oe_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////////
  a_ale_t1_span: assert property (cyc_ack_out |-> ale_out ##1 ale_out ##1 !ale_out)
    else $error("ale not high for T1");
  a_write_strobe: assert property (cyc_ack_out && cyc_attr_in.is_write |-> ##2 !wr_n_out [*4])
    else $error("write strobe short");
  a_int_ack_strobe_n_strobe: assert property (cyc_ack_out && cyc_attr_in.is_int_ack_strobe_n |-> ##2 !int_ack_strobe_n_out [*4])
    else $error("int_ack_strobe_n strobe short");
  a_read_enable: assert property (cyc_ack_out && !cyc_attr_in.is_write |->
    ##2 transceiver_enable_n_out ##1 !transceiver_enable_n_out [*2] ##1 transceiver_enable_n_out)
    else $error("read enable window wrong");
  a_write_enable: assert property (cyc_ack_out && cyc_attr_in.is_write |->
    ##2 !transceiver_enable_n_out [*5])
    else $error("write enable window wrong");
  a_select_match: assert property (cyc_ack_out |-> m_io_out == cyc_attr_in.is_mem &&
    transceiver_direction_out == cyc_attr_in.is_write)
    else $error("select or direction wrong");
  a_select_stable: assert property (cyc_ack_out |=>
    ($stable(m_io_out) && $stable(transceiver_direction_out)) [*6])
    else $error("select moved in cycle");
  a_lock_follow: assert property (bus_oe_out && !$past(reset_in) |->
    lock_n_out == !$past(lock_active_in))
    else $error("lock does not follow");
  a_hold_floats: assert property (bus_hold_ack_out |-> !bus_oe_out)
    else $error("bus driven in hold");
  a_hold_drop_float: assert property ($fell(bus_hold_ack_out) |-> !bus_oe_out)
    else $error("bus driven after hold");
  a_grant_pulse: assert property ($rose(request_grant_line_hi_pri_oe_out) |-> !bus_oe_out
    ##1 request_grant_line_hi_pri_oe_out ##1 !request_grant_line_hi_pri_oe_out)
    else $error("grant pulse wrong");
  // Main scenarios reached
  c_write: cover property (cyc_ack_out && cyc_attr_in.is_write);
  c_hold: cover property ($rose(bus_hold_ack_out));
  c_grant: cover property ($rose(request_grant_line_hi_pri_oe_out));
endmodule : bus_ctl_sva

// *** verification/bus_master_model.sv ***
/* Other local bus master: hold requester and request/grant pulses.
   Assumes a pulled-up line resolved by the testbench. */
`timescale 1ns/100ps
module bus_master_model #(parameter int HOLD_CLKS = 6) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Commands from the bench
  input wire logic go_hold_in,
  input wire logic go_rg_in,
  // Line and outputs
  input wire logic rg_line_in,
  output logic hold_req_out,
  output logic rg_pull_out,
  output logic rg_busy_out
);
  logic [2:0] st_reg; // Exchange state
  logic [3:0] cnt_reg; // Clocks in state
  assign rg_busy_out = (st_reg != 3'h0);
  always_ff @(posedge clk_sys_in)
    hold_req_out <= reset_in ? 1'h0 : go_hold_in;
  // request, wait grant, hold, release pulses
  always_ff @(posedge clk_sys_in)
  begin
    cnt_reg <= cnt_reg + 4'h1;
    if (reset_in)
    begin
      st_reg <= 3'h0;
      rg_pull_out <= 1'h0;
    end
    else
    case (st_reg)
      3'h0: if (go_rg_in)
      begin
        st_reg <= 3'h1;
        rg_pull_out <= 1'h1;
        cnt_reg <= 4'h0;
      end
      3'h1, 3'h5: if (cnt_reg == 4'h1)
      begin
        rg_pull_out <= 1'h0;
        st_reg <= (st_reg == 3'h1) ? 3'h2 : 3'h0;
      end
      3'h2: if (!rg_line_in) st_reg <= 3'h3;
      3'h3: if (rg_line_in)
      begin
        st_reg <= 3'h4;
        cnt_reg <= 4'h0;
      end
      default: if (cnt_reg == 4'(HOLD_CLKS))
      begin
        st_reg <= 3'h5;
        rg_pull_out <= 1'h1;
        cnt_reg <= 4'h0;
      end
    endcase
  end
endmodule : bus_master_model

// *** verification/testbench.sv ***
/* Testbench for the bus control and hold block.
   Assumes the package compiled first; two master models on the lines. */
`timescale 1ns/100ps
module testbench;
  logic clk_sys_in = 1'h0;
  logic reset_in = 1'h1;
  logic cyc_req = 1'h0;
  logic [4:0] attr = 5'h0;
  logic ready = 1'h1;
  logic lock_act = 1'h0;
  logic [1:0] qop = 2'h0;
  logic go_hold = 1'h0;
  logic [1:0] go_rg = 2'h0;
  logic [1:0] pull, busy, oe, line, qs, rg_lvl;
  logic hold_req, ack, done, ale, wr_n, ia_n, m_io, dir, den_n, lock_n, bus_oe, bus_hold_ack;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n_wr, n_ia, n_den, n_ha;
  // Pulled-up lines, low when anyone pulls
  assign line = ~(pull | oe);
  always #20 clk_sys_in = ~clk_sys_in;
  cpu_local_bus_control_and_hold uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .cyc_req_in(cyc_req), .cyc_attr_in(bus_ctl_pkg::cyc_attr_t'(attr)), .ready_in(ready),
    .lock_active_in(lock_act), .queue_op_in(qop), .cyc_ack_out(ack), .cyc_done_out(done),
    .ale_out(ale), .wr_n_out(wr_n), .int_ack_strobe_n_out(ia_n), .m_io_out(m_io),
    .transceiver_direction_out(dir), .transceiver_enable_n_out(den_n), .lock_n_out(lock_n),
    .bus_oe_out(bus_oe), .queue_status_out(qs), .hold_req_in(hold_req),
    .bus_hold_ack_out(bus_hold_ack), .request_grant_line_hi_pri_in(line[0]),
    .request_grant_line_hi_pri_out(rg_lvl[0]), .request_grant_line_hi_pri_oe_out(oe[0]),
    .request_grant_line_lo_pri_in(line[1]), .request_grant_line_lo_pri_out(rg_lvl[1]),
    .request_grant_line_lo_pri_oe_out(oe[1]));
  bus_master_model m_hi (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .go_hold_in(go_hold),
    .go_rg_in(go_rg[0]), .rg_line_in(line[0]), .hold_req_out(hold_req),
    .rg_pull_out(pull[0]), .rg_busy_out(busy[0]));
  bus_master_model m_lo (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .go_hold_in(1'h0),
    .go_rg_in(go_rg[1]), .rg_line_in(line[1]), .hold_req_out(),
    .rg_pull_out(pull[1]), .rg_busy_out(busy[1]));
  ////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %0t %s: saw %0d want %0d", $time, what, seen, exp);
    end
  endtask : check
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  // Watched level by number: ack, hold ack, grant enables, model busy
  function automatic logic pick(input int sel);
    logic [5:0] all;
    all = {busy, oe, bus_hold_ack, ack};
    return all[sel];
  endfunction : pick
  // Bounded wait for a level on a picked signal
  task automatic wait_for(input int sel, input logic v, output int k);
    k = 0;
    do
    begin
      @(posedge clk_sys_in);
      #1;
      k++;
    end
    while (pick(sel) !== v && k < 40);
  endtask : wait_for
  // One bus cycle; counts low strobes and hold ack until done
  task automatic bus_cycle(input logic [4:0] a, input int w, input logic h);
    int k;
    logic fin;
    n_wr = 0;
    n_ia = 0;
    n_den = 0;
    n_ha = 0;
    fin = 1'h0;
    @(posedge clk_sys_in);
    cyc_req <= 1'h1;
    attr <= a;
    wait_for(0, 1'h1, k);
    check(32'(m_io), 32'(a[4]), "memory select");
    check(32'(dir), 32'(a[3]), "direction");
    check(32'(bus_oe), 32'h1, "bus driven again");
    for (k = 3; k < 60 && !fin; k++)
    begin
      @(posedge clk_sys_in);
      if (k == 3) cyc_req <= 1'h0;
      if (k == 3) go_hold <= h;
      if (k == 3 && w > 0) ready <= 1'h0;
      if (k == 7 + 2 * w) ready <= 1'h1;
      #1;
      n_wr += int'(wr_n === 1'h0);
      n_ia += int'(ia_n === 1'h0);
      n_den += int'(den_n === 1'h0);
      n_ha += int'(bus_hold_ack === 1'h1);
      fin = (done === 1'h1);
    end
    check(32'(fin), 32'h1, "cycle done");
  endtask : bus_cycle
  ////////////////////////////////////////////////////////////////////
  task automatic t_queue;
    for (int q = 0; q < 4; q++)
    begin
      @(posedge clk_sys_in);
      qop <= 2'(q);
      repeat (4) @(posedge clk_sys_in);
      #1;
      check(32'(qs), 32'(q), "queue status");
    end
    $display("queue status test done");
  endtask : t_queue
  task automatic t_strobes;
    logic [4:0] at[4] = '{5'h10, 5'h08, 5'h04, 5'h18};
    int wt[4] = '{0, 1, 1, 0};
    for (int i = 0; i < 4; i++)
    begin
      bus_cycle(at[i], wt[i], 1'h0);
      check(32'(n_wr), at[i][3] ? 32'(4 + 2 * wt[i]) : 32'h0, "write low");
      check(32'(n_ia), at[i][2] ? 32'(4 + 2 * wt[i]) : 32'h0, "int_ack_strobe_n low");
      check(32'(n_den), at[i][3] ? 32'(5 + 2 * wt[i]) : 32'h2, "enable low");
    end
    $display("strobe test done");
  endtask : t_strobes
  task automatic t_idle_hold;
    int k;
    @(posedge clk_sys_in);
    go_hold <= 1'h1;
    wait_for(1, 1'h1, k);
    check(32'(k <= 6), 32'h1, "idle release time");
    check(32'(ale), 32'h0, "ale driven low in hold");
    @(posedge clk_sys_in);
    go_hold <= 1'h0;
    wait_for(1, 1'h0, k);
    check(32'(bus_oe), 32'h0, "bus floats after hold");
    $display("idle hold test done");
  endtask : t_idle_hold
  task automatic t_release;
    logic [4:0] at[4] = '{5'h18, 5'h18, 5'h11, 5'h06};
    logic lk[4] = '{1'h0, 1'h1, 1'h0, 1'h0};
    int k;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys_in);
      lock_act <= lk[i];
      bus_cycle(at[i], 0, 1'h1);
      // release in T4 only when allowed
      check(32'(n_ha > 0), 32'(i == 0), "release in T4");
      check(32'(lock_n), 32'(!lk[i]), "lock level");
      wait_for(1, 1'h1, k);
      check(32'(bus_hold_ack), 32'h1, "release at idle");
      @(posedge clk_sys_in);
      lock_act <= 1'h0;
      go_hold <= 1'h0;
      wait_for(1, 1'h0, k);
    end
    $display("cycle release test done");
  endtask : t_release
  task automatic t_rg(input int s);
    int k;
    @(posedge clk_sys_in);
    go_rg[s] <= 1'h1;
    @(posedge clk_sys_in);
    go_rg[s] <= 1'h0;
    wait_for(2 + s, 1'h1, k);
    check(32'(k <= 6), 32'h1, "grant time");
    check(32'(line[s]), 32'h0, "grant drives line low");
    check(32'(rg_lvl[s]), 32'h0, "grant level low");
    check(32'(bus_oe), 32'h0, "bus floats at grant");
    wait_for(4 + s, 1'h0, k);
    bus_cycle(5'h10, 0, 1'h0);
    $display("request grant test %0d done", s);
  endtask : t_rg
  ////////////////////////////////////////////////////////////////////
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_count++;
      $display("ERROR %0t run too long", $time);
      final_report();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'h0;
    t_queue();
    t_strobes();
    t_idle_hold();
    t_release();
    t_rg(0);
    t_rg(1);
    final_report();
  end
endmodule : testbench
bind cpu_local_bus_control_and_hold bus_ctl_sva u_sva (.clk_sys_in(clk_sys_in),
  .reset_in(reset_in), .cyc_attr_in(cyc_attr_in), .lock_active_in(lock_active_in),
  .cyc_ack_out(cyc_ack_out), .ale_out(ale_out), .wr_n_out(wr_n_out),
  .int_ack_strobe_n_out(int_ack_strobe_n_out), .m_io_out(m_io_out),
  .transceiver_direction_out(transceiver_direction_out),
  .transceiver_enable_n_out(transceiver_enable_n_out), .lock_n_out(lock_n_out),
  .bus_oe_out(bus_oe_out), .bus_hold_ack_out(bus_hold_ack_out),
  .request_grant_line_hi_pri_oe_out(request_grant_line_hi_pri_oe_out));
